// >>> shared/clk_sup_pkg.sv
// Constants and types for the clock output and PLL supervisor block.
// Assumes a 16-bit register port and a system clock near 250 MHz.
package clk_sup_pkg;

   // Register port widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [15:0] OFS_PLL_RUN     = 16'hF003;
   localparam logic [15:0] OFS_AUX_CLOCK_OUT_PIN_CTRL = 16'hF005;
   localparam logic [15:0] OFS_SUP_CTRL    = 16'hF006;
   localparam logic [15:0] OFS_SUP_STAT    = 16'hF007;
   localparam logic [15:0] OFS_GEN1_DEN    = 16'hF020;

   // Reset values
   localparam logic [15:0] RST_PLL_RUN     = 16'h0000;
   localparam logic [15:0] RST_AUX_CLOCK_OUT_PIN_CTRL = 16'h0000;
   localparam logic [15:0] RST_SUP_CTRL    = 16'h0001;
   localparam logic [15:0] RST_GEN1_DEN    = 16'h0006;

   // Field positions and widths
   localparam int RUN_BIT       = 0;
   localparam int SUP_EN_BIT    = 0;
   localparam int DRIVE_BIT     = 0;
   localparam int RATE_LSB      = 1;
   localparam int RATE_W        = 2;
   localparam int AUX_CLOCK_OUT_PIN_CFG_W  = 3;
   localparam int DEN_W         = 9;
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_UP_BIT   = 1;
   localparam int STAT_CNT_LSB  = 8;
   localparam int STAT_CNT_W    = 8;

   // Clock output divider: predivider output is the nominal system clock / ratio
   localparam int SYS_CLK_NOM_KHZ = 294912;
   localparam int PREDIV_OUT_KHZ  = 3072;
   localparam int PREDIV_RATIO    = SYS_CLK_NOM_KHZ / PREDIV_OUT_KHZ;
   localparam int HALF_BASE       = PREDIV_RATIO / 2;
   localparam int DIV_CNT_W       = 6;

   // Supervisor timing
   localparam int CLK_PERIOD_PS   = 4000;
   localparam int PLL_RST_NS      = 100;
   localparam int PLL_RST_CYC     = (PLL_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LOCK_TIMEOUT_US = 1000;
   localparam int LOCK_TIMEOUT_CYC = (LOCK_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
   localparam int REF_TIMEOUT_NS  = 2000;
   localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int TMR_W           = 18;
   localparam int REF_CNT_W       = 10;

   typedef enum logic [1:0] {
      SUP_IDLE,
      SUP_RESET,
      SUP_WAIT_LOCK,
      SUP_LOCKED
   } sup_state_t;

endpackage

// >>> shared/aux_clock_out_pin_if.sv
// Link between the register side and the clock output divider.
// Both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface aux_clock_out_pin_if;
   logic       run;
   logic       drive_on;
   logic [1:0] rate;
   logic       clk_level;

   modport ctrl (output run, output drive_on, output rate, input clk_level);
   modport gen  (input run, input drive_on, input rate, output clk_level);
endinterface
`default_nettype wire

// >>> verilog/aux_clock_out_pin_gen.sv
// Clock output divider: predivider rate times one, two, four or eight.
// Assumes the rate only changes while the divider is held idle or at run start.
`timescale 1ns/1ps
`default_nettype none
module aux_clock_out_pin_gen
   import clk_sup_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   aux_clock_out_pin_if.gen     io
);

   typedef struct packed {
      logic [DIV_CNT_W-1:0] cnt;
      logic                 level;
   } gen_state_t;

   gen_state_t st_q;
   gen_state_t st_d;
   logic [DIV_CNT_W-1:0] half;

   // Half period shrinks by a power of two per rate step; scales with the input clock
   assign half = DIV_CNT_W'(HALF_BASE) >> io.rate;

   // Divider held at zero and low while the PLL is not running or the pin is not driven;
   // nothing toggles behind a high-impedance pin
   always_comb begin
      st_d = st_q;
      if (!io.run || !io.drive_on) begin
         st_d.cnt   = '0;
         st_d.level = 1'b0;
      end else if (st_q.cnt == half - 6'h01) begin
         st_d.cnt   = '0;
         st_d.level = ~st_q.level;
      end else begin
         st_d.cnt = st_q.cnt + 6'h01;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign io.clk_level = st_q.level;

   // Helper: cycles since last toggle, valid once a full half period has passed
   logic [DIV_CNT_W-1:0] since_q;
   logic                 seen_q;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || !io.run || !io.drive_on) begin
         since_q <= 6'h00;
         seen_q  <= 1'b0;
      end else if (st_q.level != st_d.level) begin
         since_q <= 6'h01;
         seen_q  <= 1'b1;
      end else begin
         since_q <= since_q + 6'h01;
      end
   end

   half_period_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (io.run && $past(io.run) && $past(seen_q) && $changed(st_q.level)) |-> $past(since_q) == half)
      else $error("clock output half period wrong for rate");

   idle_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !io.run |=> !st_q.level)
      else $error("clock output toggles while PLL stopped");

endmodule
`default_nettype wire

// >>> verilog/clk_out_pll_supervisor.sv
// Clock output control, PLL supervisor and first clock generator denominator.
// Assumes a single-cycle register port; PLL lock and reference are asynchronous pins.
//
// Contract
// - Clock output settings are staged and loaded only on PLL run rising edge.
// - Rate field bits 2:1 select one, two, four or eight times predivider.
// - Predivider gives 3.072 MHz from a nominal 294.912 MHz system clock.
// - Output rates scale with the master clock, e.g. 2.8224 to 22.5792 MHz.
// - Drive bit 0 set drives the clock pin; clear leaves it high impedance.
// - Enabled supervisor resets PLL on instability and relocks with same settings.
// - Denominator is nine-bit unsigned in bits 8:0, reset 0x006, rest reserved.
// - With PLL run bit clear, PLL and dependent clock output stay idle.
`timescale 1ns/1ps
`default_nettype none
module clk_out_pll_supervisor
   import clk_sup_pkg::*;
#(
   parameter int LOCK_TIMEOUT = LOCK_TIMEOUT_CYC
)(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   input  wire logic              i_pll_lock,
   input  wire logic              i_ref_clk,
   output logic                   o_pll_run,
   output logic                   o_pll_reset,
   output logic      [DEN_W-1:0]  o_gen1_denominator,
   output logic                   o_aux_clock_out_pin,
   output logic                   o_aux_clock_out_pin_oe
);

   localparam int RST_LEN = PLL_RST_CYC;

   typedef struct packed {
      logic                    run;
      logic [AUX_CLOCK_OUT_PIN_CFG_W-1:0] cfg_staged;
      logic [AUX_CLOCK_OUT_PIN_CFG_W-1:0] cfg_active;
      logic                    sup_en;
      logic [DEN_W-1:0]        den;
      logic [DATA_W-1:0]       rdata;
      logic                    lock_s1;
      logic                    lock_s2;
      logic                    ref_s1;
      logic                    ref_s2;
      logic                    ref_s3;
      logic [REF_CNT_W-1:0]    ref_idle;
      sup_state_t              sup;
      logic [TMR_W-1:0]        tmr;
      logic [STAT_CNT_W-1:0]   restarts;
      logic                    pll_rst;
   } top_state_t;

   top_state_t st_q;
   top_state_t st_d;

   logic ref_lost;
   logic wr_run;
   logic wr_aux_clock_out_pin;
   logic wr_sup;
   logic wr_den;

   aux_clock_out_pin_if cio ();

   // Clock output divider on the active settings only
   aux_clock_out_pin_gen u_aux_clock_out_pin_gen (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .io        (cio.gen)
   );

   assign cio.run      = st_q.run;
   assign cio.drive_on = st_q.cfg_active[DRIVE_BIT];
   assign cio.rate     = st_q.cfg_active[RATE_LSB +: RATE_W];

   // Write decode
   always_comb begin
      wr_run    = 1'b0;
      wr_aux_clock_out_pin = 1'b0;
      wr_sup    = 1'b0;
      wr_den    = 1'b0;
      if (i_wr && i_addr == OFS_PLL_RUN) begin
         wr_run = 1'b1;
      end else if (i_wr && i_addr == OFS_AUX_CLOCK_OUT_PIN_CTRL) begin
         wr_aux_clock_out_pin = 1'b1;
      end else if (i_wr && i_addr == OFS_SUP_CTRL) begin
         wr_sup = 1'b1;
      end else if (i_wr && i_addr == OFS_GEN1_DEN) begin
         wr_den = 1'b1;
      end
   end

   // Reference considered gone once no edge seen for the full timeout
   assign ref_lost = (st_q.ref_idle == REF_CNT_W'(REF_TIMEOUT_CYC));

   // All next-state logic
   always_comb begin
      st_d = st_q;

      // Pin synchronisers; lock uses the second stage, reference edges compare second and third
      st_d.lock_s1 = i_pll_lock;
      st_d.lock_s2 = st_q.lock_s1;
      st_d.ref_s1  = i_ref_clk;
      st_d.ref_s2  = st_q.ref_s1;
      st_d.ref_s3  = st_q.ref_s2;

      // Reference activity watchdog, saturating
      if (st_q.ref_s2 != st_q.ref_s3) begin
         st_d.ref_idle = '0;
      end else if (!ref_lost) begin
         st_d.ref_idle = st_q.ref_idle + 10'h001;
      end

      // Register writes
      if (wr_run) begin
         st_d.run = i_wdata[RUN_BIT];
         // Staged settings go live only on the off-to-on edge
         if (i_wdata[RUN_BIT] && !st_q.run) begin
            st_d.cfg_active = st_q.cfg_staged;
         end
      end
      if (wr_aux_clock_out_pin) begin
         st_d.cfg_staged = i_wdata[AUX_CLOCK_OUT_PIN_CFG_W-1:0];
      end
      if (wr_sup) begin
         st_d.sup_en = i_wdata[SUP_EN_BIT];
      end
      if (wr_den) begin
         st_d.den = i_wdata[DEN_W-1:0];
      end

      // Read data, one cycle after the strobe; unmapped reads zero
      st_d.rdata = '0;
      if (i_rd && i_addr == OFS_PLL_RUN) begin
         st_d.rdata[RUN_BIT] = st_q.run;
      end else if (i_rd && i_addr == OFS_AUX_CLOCK_OUT_PIN_CTRL) begin
         st_d.rdata[AUX_CLOCK_OUT_PIN_CFG_W-1:0] = st_q.cfg_staged;
      end else if (i_rd && i_addr == OFS_SUP_CTRL) begin
         st_d.rdata[SUP_EN_BIT] = st_q.sup_en;
      end else if (i_rd && i_addr == OFS_SUP_STAT) begin
         st_d.rdata[STAT_LOCK_BIT] = st_q.lock_s2;
         st_d.rdata[STAT_UP_BIT]   = (st_q.sup == SUP_LOCKED);
         st_d.rdata[STAT_CNT_LSB +: STAT_CNT_W] = st_q.restarts;
      end else if (i_rd && i_addr == OFS_GEN1_DEN) begin
         st_d.rdata[DEN_W-1:0] = st_q.den;
      end

      // Supervisor; settings registers are never touched here, so relock reuses them
      st_d.pll_rst = 1'b0;
      case (st_q.sup)
         SUP_IDLE: begin
            st_d.tmr = '0;
            if (st_q.run) begin
               st_d.sup = SUP_WAIT_LOCK;
            end
         end
         SUP_WAIT_LOCK: begin
            st_d.tmr = st_q.tmr + 18'h00001;
            if (!st_q.run) begin
               st_d.sup = SUP_IDLE;
            end else if (st_q.lock_s2) begin
               st_d.sup = SUP_LOCKED;
            end else if (st_q.sup_en && st_q.tmr >= TMR_W'(LOCK_TIMEOUT - 1)) begin
               // Lock never came: retry from a fresh reset
               st_d.sup     = SUP_RESET;
               st_d.tmr     = '0;
               st_d.pll_rst = 1'b1;
            end
         end
         SUP_LOCKED: begin
            st_d.tmr = '0;
            if (!st_q.run) begin
               st_d.sup = SUP_IDLE;
            end else if (st_q.sup_en && (!st_q.lock_s2 || ref_lost)) begin
               st_d.sup     = SUP_RESET;
               st_d.pll_rst = 1'b1;
               if (st_q.restarts != 8'hFF) begin
                  st_d.restarts = st_q.restarts + 8'h01;
               end
            end
         end
         SUP_RESET: begin
            st_d.tmr = st_q.tmr + 18'h00001;
            if (!st_q.run) begin
               st_d.sup = SUP_IDLE;
            end else if (st_q.tmr >= TMR_W'(RST_LEN - 1)) begin
               st_d.sup = SUP_WAIT_LOCK;
               st_d.tmr = '0;
            end else begin
               st_d.pll_rst = 1'b1;
            end
         end
         default: begin
            st_d.sup = SUP_IDLE;
         end
      endcase
   end

   // State register with documented reset values
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_q            <= '0;
         st_q.run        <= RST_PLL_RUN[RUN_BIT];
         st_q.cfg_staged <= RST_AUX_CLOCK_OUT_PIN_CTRL[AUX_CLOCK_OUT_PIN_CFG_W-1:0];
         st_q.cfg_active <= RST_AUX_CLOCK_OUT_PIN_CTRL[AUX_CLOCK_OUT_PIN_CFG_W-1:0];
         st_q.sup_en     <= RST_SUP_CTRL[SUP_EN_BIT];
         st_q.den        <= RST_GEN1_DEN[DEN_W-1:0];
         st_q.sup        <= SUP_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs; PLL held off while run bit clear
   assign o_rdata                = st_q.rdata;
   assign o_pll_run              = st_q.run;
   assign o_pll_reset            = st_q.pll_rst;
   assign o_gen1_denominator     = st_q.den;
   assign o_aux_clock_out_pin    = cio.clk_level;
   assign o_aux_clock_out_pin_oe = st_q.cfg_active[DRIVE_BIT];

   cfg_staged_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $changed(st_q.cfg_active) |-> $rose(st_q.run))
      else $error("active clock output settings changed without run edge");

   cfg_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(st_q.run) |-> st_q.cfg_active == $past(st_q.cfg_staged))
      else $error("run edge did not load staged settings");

   pin_hiz_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_pll_run) |-> o_aux_clock_out_pin_oe == $past(st_q.cfg_staged[DRIVE_BIT]))
      else $error("clock pin enable does not follow drive bit");

   pin_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!o_pll_run && $past(!o_pll_run)) |-> !o_aux_clock_out_pin)
      else $error("clock pin active while PLL stopped");

   lock_loss_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (st_q.sup == SUP_LOCKED && st_q.run && st_q.sup_en && !st_q.lock_s2) |=> o_pll_reset ##1 o_pll_reset)
      else $error("lost lock did not reset PLL");

   rst_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      ($rose(o_pll_reset) && o_pll_run) |->
      ##[1:RST_LEN] ((!o_pll_reset && st_q.sup == SUP_WAIT_LOCK) || !o_pll_run))
      else $error("PLL reset pulse did not end in relock attempt");

   sup_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (!st_q.sup_en && st_q.sup == SUP_LOCKED) |=> !o_pll_reset)
      else $error("disabled supervisor reset the PLL");

   den_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == OFS_GEN1_DEN) |=>
      (o_rdata[DATA_W-1:DEN_W] == '0 && o_rdata[DEN_W-1:0] == o_gen1_denominator))
      else $error("denominator read wrong or reserved bits set");

endmodule
`default_nettype wire

// >>> tb/clk_out_pll_supervisor_tb_top.sv
// Self-checking bench for the clock output, PLL supervisor and denominator block.
// Assumes the package constants and a lock timeout shortened to 200 cycles.
`timescale 1ns/1ps
`default_nettype none
module clk_out_pll_supervisor_tb_top
   import clk_sup_pkg::*;
;
   typedef struct {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } row_t;

   logic              i_sys_clk;
   logic              i_rst_n;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata;
   logic              i_wr;
   logic              i_rd;
   logic              i_pll_lock;
   logic              i_ref_clk;
   logic              ref_on;
   logic [2:0]        ref_div;
   logic [DATA_W-1:0] o_rdata;
   logic              o_pll_run;
   logic              o_pll_reset;
   logic [DEN_W-1:0]  o_gen1_denominator;
   logic              o_aux_clock_out_pin;
   logic              o_aux_clock_out_pin_oe;
   int                errors;
   int                total_checks;
   row_t              rows [6];
   logic [15:0]       rd_val;
   int                n;

   clk_out_pll_supervisor #(.LOCK_TIMEOUT(200)) dut (
      .i_sys_clk              (i_sys_clk),
      .i_rst_n                (i_rst_n),
      .i_addr                 (i_addr),
      .i_wdata                (i_wdata),
      .i_wr                   (i_wr),
      .i_rd                   (i_rd),
      .o_rdata                (o_rdata),
      .i_pll_lock             (i_pll_lock),
      .i_ref_clk              (i_ref_clk),
      .o_pll_run              (o_pll_run),
      .o_pll_reset            (o_pll_reset),
      .o_gen1_denominator     (o_gen1_denominator),
      .o_aux_clock_out_pin    (o_aux_clock_out_pin),
      .o_aux_clock_out_pin_oe (o_aux_clock_out_pin_oe)
   );

   // 250 MHz system clock
   initial begin
      i_sys_clk = 1'b0;
   end
   always #2 i_sys_clk = ~i_sys_clk;

   // Reference clock stand-in, one edge every eight cycles so the 500-cycle watch never trips
   always @(posedge i_sys_clk) begin
      if (ref_on) begin
         ref_div <= ref_div + 3'h1;
         if (ref_div == 3'h7) begin
            i_ref_clk <= ~i_ref_clk;
         end
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Each access starts on a fresh edge so strobes never collide in one time step
   task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_sys_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd   <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   // Cycles until the pin changes; call twice, the first only aligns to an edge
   task automatic half_period(output int cnt);
      logic p0;
      cnt = 0;
      p0 = o_aux_clock_out_pin;
      while (o_aux_clock_out_pin === p0 && cnt < 200) begin
         @(posedge i_sys_clk);
         #1;
         cnt++;
      end
      // A stuck pin ends the run
      if (cnt >= 200) begin
         errors++;
         close_out();
      end
   endtask

   // Waits up to lim cycles for the PLL reset, then returns its width in cycles
   task automatic reset_width(input int lim, input bit must, output int w);
      int k;
      k = 0;
      w = 0;
      while (o_pll_reset !== 1'b1 && k < lim) begin
         @(posedge i_sys_clk);
         #1;
         k++;
      end
      // A pulse that was due and never came ends the run
      if (must && k >= lim) begin
         errors++;
         close_out();
      end
      while (o_pll_reset === 1'b1 && w < 100) begin
         @(posedge i_sys_clk);
         #1;
         w++;
      end
      if (w >= 100) begin
         errors++;
         close_out();
      end
   endtask

   task automatic close_out();
      $display("checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      #400000;
      errors++;
      close_out();
   end

   initial begin
      i_rst_n = 1'b0;
      i_addr = 16'h0000;
      i_wdata = 16'h0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_pll_lock = 1'b0;
      i_ref_clk = 1'b0;
      ref_on = 1'b1;
      ref_div = 3'h0;
      errors = 0;
      total_checks = 0;
      rows[0] = '{16'hF005, 16'hFFFF, 16'h0007};
      rows[1] = '{16'hF006, 16'hFFFE, 16'h0000};
      rows[2] = '{16'hF006, 16'hFFFF, 16'h0001};
      rows[3] = '{16'hF020, 16'hFFFF, 16'h01FF};
      rows[4] = '{16'hF020, 16'h0123, 16'h0123};
      rows[5] = '{16'h1234, 16'hFFFF, 16'h0000};
      repeat (20) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      // Reset values straight after release
      reg_rd(16'hF005, rd_val);
      chk(rd_val, 16'h0000);
      reg_rd(16'hF006, rd_val);
      chk(rd_val, 16'h0001);
      reg_rd(16'hF020, rd_val);
      chk(rd_val, 16'h0006);
      chk({15'h0000, o_aux_clock_out_pin_oe}, 16'h0000);
      $display("test reset values done");
      // Table rows: write, read back, reserved bits must read zero
      foreach (rows[i]) begin
         reg_wr(rows[i].addr, rows[i].wdata);
         reg_rd(rows[i].addr, rd_val);
         chk(rd_val, rows[i].exp);
      end
      chk({7'h00, o_gen1_denominator}, 16'h0123);
      $display("test register table done");
      // Staged settings do nothing while run stays low
      i_pll_lock <= 1'b1;
      reg_wr(16'hF005, 16'h0001);
      repeat (100) @(posedge i_sys_clk);
      #1;
      chk({15'h0000, o_aux_clock_out_pin_oe}, 16'h0000);
      chk({15'h0000, o_aux_clock_out_pin}, 16'h0000);
      // Each rate: stage, raise run, measure the half period
      for (int r = 0; r < 4; r++) begin
         reg_wr(16'hF003, 16'h0000);
         reg_wr(16'hF005, 16'(r * 2 + 1));
         reg_wr(16'hF003, 16'h0001);
         #1;
         chk({15'h0000, o_aux_clock_out_pin_oe}, 16'h0001);
         half_period(n);
         half_period(n);
         chk(16'(n), 16'(HALF_BASE >> r));
      end
      $display("test clock rates done");
      // Drive off while running: held until the next run rising edge
      reg_wr(16'hF005, 16'h0000);
      repeat (50) @(posedge i_sys_clk);
      #1;
      chk({15'h0000, o_aux_clock_out_pin_oe}, 16'h0001);
      reg_wr(16'hF003, 16'h0000);
      repeat (100) @(posedge i_sys_clk);
      #1;
      chk({15'h0000, o_aux_clock_out_pin}, 16'h0000);
      reg_wr(16'hF003, 16'h0001);
      #1;
      chk({15'h0000, o_aux_clock_out_pin_oe}, 16'h0000);
      $display("test staging done");
      // Supervisor: lost lock gives one 25-cycle reset, settings kept
      repeat (20) @(posedge i_sys_clk);
      reg_rd(16'hF007, rd_val);
      chk(rd_val & 16'h0003, 16'h0003);
      i_pll_lock <= 1'b0;
      reset_width(20, 1'b1, n);
      i_pll_lock <= 1'b1;
      chk(16'(n), 16'(PLL_RST_CYC));
      reg_rd(16'hF020, rd_val);
      chk(rd_val, 16'h0123);
      chk({15'h0000, o_pll_run}, 16'h0001);
      // Missing reference clock also counts as instability
      repeat (30) @(posedge i_sys_clk);
      reg_rd(16'hF007, rd_val);
      chk(rd_val, 16'h0103);
      ref_on <= 1'b0;
      reset_width(600, 1'b1, n);
      ref_on <= 1'b1;
      chk(16'(n), 16'(PLL_RST_CYC));
      $display("test supervisor done");
      // Supervisor off: a lost lock raises no reset
      repeat (30) @(posedge i_sys_clk);
      reg_wr(16'hF006, 16'h0000);
      i_pll_lock <= 1'b0;
      reset_width(300, 1'b0, n);
      chk(16'(n), 16'h0000);
      // Re-enabled with lock still low: reset at once, then the lock timeout retries
      reg_wr(16'hF006, 16'h0001);
      reset_width(20, 1'b1, n);
      chk(16'(n), 16'(PLL_RST_CYC));
      reset_width(300, 1'b1, n);
      chk(16'(n), 16'(PLL_RST_CYC));
      $display("test supervisor disabled done");
      // Second reset mid-run restores the register defaults
      @(posedge i_sys_clk);
      i_rst_n <= 1'b0;
      repeat (20) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      reg_rd(16'hF006, rd_val);
      chk(rd_val, 16'h0001);
      chk({7'h00, o_gen1_denominator}, 16'h0006);
      chk({15'h0000, o_pll_run}, 16'h0000);
      $display("test second reset done");
      close_out();
   end
endmodule
`default_nettype wire
